// File: rcoa_pkg.sv
`default_nettype none

package rcoa_pkg;

    // Status exchange period and the system clock period.
    localparam int unsigned PERIOD_S = 32'h0000_0001;
    localparam int unsigned CLK_NS   = 32'h0000_0028;
    localparam int unsigned NS_PER_S = 32'h3B9A_CA00;
    localparam int unsigned SEC_CYC  = PERIOD_S * NS_PER_S / CLK_NS;

    // Missed exchange periods before the peer is taken as absent.
    localparam logic [1:0]  PEER_TMO = 2'h3;

    localparam int unsigned HEALTH_W = 32'h0000_0008;
    localparam int unsigned NONCE_W  = 32'h0000_0008;
    localparam logic [7:0]  NONCE_RST = 8'h5A;
    localparam logic [7:0]  NONCE_TAP = 8'hB8;

    // Outcome of a status comparison.
    localparam logic [1:0] CMP_TIE  = 2'h0;
    localparam logic [1:0] CMP_WIN  = 2'h1;
    localparam logic [1:0] CMP_LOSE = 2'h2;

    typedef enum logic [2:0] {
        ST_WAIT = 3'b001,
        ST_OFF  = 3'b010,
        ST_ON   = 3'b100
    } rcoa_state_t;

    typedef struct packed {
        logic                online;
        logic                stable_tb;
        logic [NONCE_W-1:0]  nonce;
        logic [HEALTH_W-1:0] health;
    } rcoa_status_t;

    typedef struct packed {
        logic jumper;
        logic wdog;
        logic peer_dis;
        logic shape_ok;
        logic level_ok;
        logic loop_ok;
        logic locked;
    } rcoa_pins_t;

    // The jumper resets as set, so the drivers stay off until the real jumper is seen.
    localparam rcoa_pins_t PINS_RST = 7'h40;

endpackage

`default_nettype wire

// File: rcoa_arbiter.sv
// Operation
// - Every second the clock sends its health status to the peer and accepts the peer's status.
// - A clock less healthy than its peer gives up on-line status so the peer drives.
// - A watchdog fault hands on-line status to the peer directly in hardware; reset clears the disable output.
// - On comparison the clock with the lower status byte is elected on-line.
// - With equal status a higher-stability timebase wins, otherwise the choice is arbitrary.
// - Election is symmetric and does not depend on which cable end a clock sits on.
// - With the redundant jumper set, digital drivers are enabled only while on-line.
// - The output enable gates only the digital outputs, not the modulated or recorder outputs.
// - The distribution-bus relay follows the same output enable.
// - The on-line indicator is lit only while the jumper is set and the clock is on-line.
// - A bus fault is raised for lost drive, an open bus or a shorted bus.
// - The bus is healthy only with a code-like waveshape and a level above threshold.
// - Fault and unlocked relays are energized in normal operation with no fault.
// - Each relay is released when unpowered or in its fault or unlocked state.
// - A bus fault is shown on the fault indicator, the fault relay and the serial port.
`timescale 1ns/1ns
`default_nettype none

module rcoa_arbiter #(
    parameter int unsigned SEC_CYC = rcoa_pkg::SEC_CYC
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire rcoa_pkg::rcoa_pins_t  pins_in,
    input  wire logic [7:0]            local_health,
    input  wire logic                  stable_tb,
    input  wire rcoa_pkg::rcoa_status_t rx_status,
    input  wire logic                  rx_valid,
    output var rcoa_pkg::rcoa_status_t tx_status,
    output var logic                   tx_send,
    output var logic                   disable_out,
    output var logic                   digital_oe,
    output var logic                   bus_relay,
    output var logic                   online_led,
    output var logic                   bus_fault,
    output var logic                   fault_led,
    output var logic                   fault_relay,
    output var logic                   unlocked_relay,
    output var logic                   fault_report,
    output var logic                   peer_lost
);

    localparam int CW = $clog2(SEC_CYC);

    // Lower byte wins; on equal bytes the stabler timebase wins.
    function automatic logic [1:0] rcoa_cmp(
        input rcoa_pkg::rcoa_status_t mine,
        input rcoa_pkg::rcoa_status_t peer
    );
        logic [1:0] r;
        r = rcoa_pkg::CMP_TIE;
        if (mine.health < peer.health) begin
            r = rcoa_pkg::CMP_WIN;
        end else if (mine.health > peer.health) begin
            r = rcoa_pkg::CMP_LOSE;
        end else if (mine.stable_tb && !peer.stable_tb) begin
            r = rcoa_pkg::CMP_WIN;
        end else if (!mine.stable_tb && peer.stable_tb) begin
            r = rcoa_pkg::CMP_LOSE;
        end
        return r;
    endfunction

    rcoa_pkg::rcoa_pins_t  meta_reg;
    rcoa_pkg::rcoa_pins_t  pin_reg;
    rcoa_pkg::rcoa_state_t state_reg;
    rcoa_pkg::rcoa_state_t state_next;
    rcoa_pkg::rcoa_status_t tx_reg;
    rcoa_pkg::rcoa_status_t tx_next;
    rcoa_pkg::rcoa_status_t mine;
    logic [CW-1:0]         sec_reg;
    logic [CW-1:0]         sec_next;
    logic [1:0]            miss_reg;
    logic [1:0]            miss_next;
    logic [7:0]            nonce_reg;
    logic [7:0]            nonce_next;
    logic                  send_reg;
    logic                  send_next;
    logic                  dis_reg;
    logic                  dis_next;
    logic                  bfault_reg;
    logic                  bfault_next;
    logic                  lost;
    logic                  online;
    logic [1:0]            res;

    assign online = (state_reg == rcoa_pkg::ST_ON);
    assign lost   = (miss_reg == rcoa_pkg::PEER_TMO);

    always_comb begin
        mine           = '0;
        mine.online    = online;
        mine.stable_tb = stable_tb;
        mine.nonce     = nonce_reg;
        mine.health    = local_health;
        res            = rcoa_cmp(mine, rx_status);
    end

    // Pins reach the logic only through the second flop.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_reg <= rcoa_pkg::PINS_RST;
            pin_reg  <= rcoa_pkg::PINS_RST;
        end else if (clk_en) begin
            meta_reg <= pins_in;
            pin_reg  <= meta_reg;
        end
    end

    always_comb begin
        sec_next   = sec_reg + CW'(1);
        send_next  = 1'b0;
        tx_next    = tx_reg;
        miss_next  = miss_reg;
        nonce_next = {nonce_reg[6:0], ^(nonce_reg & rcoa_pkg::NONCE_TAP)};
        if (sec_reg == CW'(SEC_CYC - 1)) begin
            sec_next  = '0;
            send_next = 1'b1;
            tx_next   = mine;
            if (!lost) begin
                miss_next = miss_reg + 2'h1;
            end
        end
        if (rx_valid) begin
            miss_next = 2'h0;
        end
    end

    always_comb begin
        state_next = state_reg;
        if (pin_reg.wdog) begin
            state_next = rcoa_pkg::ST_OFF;
        end else if (pin_reg.peer_dis) begin
            state_next = rcoa_pkg::ST_ON;
        end else if (rx_valid) begin
            case (res)
                rcoa_pkg::CMP_LOSE: state_next = rcoa_pkg::ST_OFF;
                rcoa_pkg::CMP_WIN:  state_next = rcoa_pkg::ST_ON;
                default: begin
                    if (rx_status.online) begin
                        state_next = rcoa_pkg::ST_OFF;
                    end else if (online || nonce_reg < rx_status.nonce) begin
                        state_next = rcoa_pkg::ST_ON;
                    end else begin
                        state_next = rcoa_pkg::ST_OFF;
                    end
                end
            endcase
        end else if (lost) begin
            state_next = rcoa_pkg::ST_ON;
        end
    end

    always_comb begin
        dis_next    = pin_reg.wdog;
        bfault_next = !(pin_reg.shape_ok && pin_reg.level_ok && pin_reg.loop_ok);
    end

    // start disabled in the wait state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg  <= rcoa_pkg::ST_WAIT;
            sec_reg    <= '0;
            miss_reg   <= 2'h0;
            nonce_reg  <= rcoa_pkg::NONCE_RST;
            send_reg   <= 1'b0;
            tx_reg     <= '0;
            dis_reg    <= 1'b0;
            bfault_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg  <= state_next;
            sec_reg    <= sec_next;
            miss_reg   <= miss_next;
            nonce_reg  <= nonce_next;
            send_reg   <= send_next;
            tx_reg     <= tx_next;
            dis_reg    <= dis_next;
            bfault_reg <= bfault_next;
        end
    end

    assign tx_status   = tx_reg;
    assign tx_send     = send_reg;
    assign disable_out = dis_reg;
    assign peer_lost   = lost;
    // analog outputs are not gated here
    assign digital_oe  = !pin_reg.jumper || online;
    assign bus_relay   = !pin_reg.jumper || online;
    assign online_led  = pin_reg.jumper && online;
    assign bus_fault   = bfault_reg;
    // fault shown on led and serial
    assign fault_led    = bfault_reg || dis_reg;
    assign fault_report = bfault_reg;
    assign fault_relay    = !(bfault_reg || dis_reg);
    assign unlocked_relay = pin_reg.locked;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst || !clk_en);

    a_tx_period: assert property (
        $rose(send_reg) |=> !send_reg[*8])
        else $error("status sent twice within a period");
    a_less_healthy: assert property (
        rx_valid && !pin_reg.wdog && !pin_reg.peer_dis
        && rx_status.health < local_health |=> !online)
        else $error("less healthy clock stayed on-line");
    a_wdog_handover: assert property (
        pin_reg.wdog |=> !online && disable_out)
        else $error("watchdog fault kept on-line status");
    a_lower_wins: assert property (
        rx_valid && !pin_reg.wdog && rx_status.health > local_health |=> online)
        else $error("lower status byte not elected");
    a_tb_tie: assert property (
        rx_valid && !pin_reg.wdog && !pin_reg.peer_dis
        && rx_status.health == local_health && stable_tb && !rx_status.stable_tb
        |=> online)
        else $error("stable timebase lost a tie");
    a_oe_gate: assert property (
        pin_reg.jumper && !online |-> !digital_oe && !bus_relay)
        else $error("drivers enabled while off-line");
    a_led_match: assert property (
        online_led |-> digital_oe && online)
        else $error("indicator lit without on-line enable");
    a_bus_fault: assert property (
        !pin_reg.level_ok |=> bus_fault && !fault_relay)
        else $error("low level not flagged as bus fault");
    a_peer_disable: assert property (
        pin_reg.peer_dis && !pin_reg.wdog |=> online)
        else $error("peer disable did not bring clock on-line");
    a_reset_hold: assert property (
        state_reg == rcoa_pkg::ST_WAIT && pin_reg.jumper |-> !digital_oe && !bus_relay
        && !online_led)
        else $error("outputs enabled before first decision");
    a_relay_follow: assert property (
        bus_relay == digital_oe)
        else $error("bus relay differs from output enable");
    a_led_dark: assert property (
        !pin_reg.jumper |-> !online_led)
        else $error("indicator lit without redundant control");
    a_jumper_free: assert property (
        !pin_reg.jumper |-> digital_oe)
        else $error("drivers gated without redundant control");
    a_fault_report: assert property (
        bus_fault |-> fault_led && fault_report && !fault_relay)
        else $error("bus fault not reported");
    a_relay_healthy: assert property (
        !bus_fault && !disable_out |-> fault_relay)
        else $error("fault relay released with no fault");
    a_locked_relay: assert property (
        pin_reg.locked |-> unlocked_relay)
        else $error("unlocked relay released while locked");
    a_unlock_relay: assert property (
        !pin_reg.locked |-> !unlocked_relay)
        else $error("unlocked relay energized while unlocked");
    a_open_fault: assert property (
        !pin_reg.loop_ok || !pin_reg.shape_ok |=> bus_fault)
        else $error("open bus or lost drive not flagged");
    a_tie_peer_on: assert property (
        rx_valid && !pin_reg.wdog && !pin_reg.peer_dis && res == rcoa_pkg::CMP_TIE
        && rx_status.online |=> !online)
        else $error("tie did not leave the on-line peer driving");
    a_lost_online: assert property (
        lost && !rx_valid && !pin_reg.wdog && !pin_reg.peer_dis |=> online)
        else $error("clock stayed off with its peer lost");
    a_release_dis: assert property (
        !pin_reg.wdog |=> !disable_out)
        else $error("disable driven without a watchdog fault");

    c_go_online: cover property ($rose(online));
    c_handover: cover property (online ##1 pin_reg.wdog ##1 !online);
    c_peer_lost: cover property ($rose(lost));
    c_bus_fault: cover property ($rose(bus_fault));
    c_peer_takeover: cover property ($rose(pin_reg.peer_dis) ##1 online);

endmodule

`default_nettype wire

// File: rcoa_peer_model.sv
`timescale 1ns/1ns
`default_nettype none

module rcoa_peer_model (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   tx_send,
    input  wire rcoa_pkg::rcoa_status_t peer_stat,
    input  wire logic                   mute,
    input  wire logic                   fail,
    output var rcoa_pkg::rcoa_status_t  rx_status,
    output var logic                    rx_valid,
    output var logic                    dis_out
);
    // Whole status per exchange.
    // Between answers the lines toggle, so a stale status never passes for a fresh one.
    always_ff @(posedge sys_clk) begin
        rx_valid  <= tx_send && !mute && !sys_rst;
        rx_status <= tx_send ? peer_stat : ~rx_status;
    end

    always_ff @(posedge sys_clk) begin
        dis_out <= fail && !sys_rst;
    end
endmodule

`default_nettype wire

// File: redundant_clock_online_arbiter_bench.sv
`timescale 1ns/1ns
`default_nettype none

module redundant_clock_online_arbiter_bench;
    localparam int unsigned SEC    = 16;
    localparam logic [7:0]  OWN_H [5] = '{8'h10, 8'h30, 8'h00, 8'h40, 8'h40};
    localparam logic [7:0]  PEER_H [5] = '{8'h20, 8'h20, 8'hFF, 8'h40, 8'h40};
    localparam logic [4:0]  OWN_S  = 5'h08;
    localparam logic [4:0]  PEER_S = 5'h10;
    localparam logic [4:0]  EXP_ON = 5'h0D;
    localparam logic [2:0]  BUS [4] = '{3'h6, 3'h5, 3'h3, 3'h7};

    logic                   sys_clk, sys_rst, jumper, wdog, shape_ok, level_ok, loop_ok, locked;
    logic                   clk_en;
    logic                   stable_tb, mute, fail, dis_w, rx_valid, tx_send, disable_out;
    logic                   digital_oe, bus_relay, online_led, bus_fault, fault_led;
    logic                   fault_relay, unlocked_relay, fault_report, peer_lost;
    logic [7:0]             local_health;
    rcoa_pkg::rcoa_status_t peer_stat, rx_status, tx_status;
    rcoa_pkg::rcoa_pins_t   pins;
    int                     num_errors, samples_checked, n;
    int                     cycles = 0;

    assign pins = {jumper, wdog, dis_w, shape_ok, level_ok, loop_ok, locked};

    rcoa_arbiter #(.SEC_CYC(SEC)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .pins_in(pins),
        .local_health(local_health), .stable_tb(stable_tb), .rx_status(rx_status),
        .rx_valid(rx_valid), .tx_status(tx_status), .tx_send(tx_send),
        .disable_out(disable_out), .digital_oe(digital_oe), .bus_relay(bus_relay),
        .online_led(online_led), .bus_fault(bus_fault), .fault_led(fault_led),
        .fault_relay(fault_relay), .unlocked_relay(unlocked_relay),
        .fault_report(fault_report), .peer_lost(peer_lost)
    );

    rcoa_peer_model peer (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .tx_send(tx_send), .peer_stat(peer_stat),
        .mute(mute), .fail(fail), .rx_status(rx_status), .rx_valid(rx_valid),
        .dis_out(dis_w)
    );

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Returns at the falling edge after the design has taken a peer status.
    task automatic exch;
        n = 0;
        do @(negedge sys_clk); while (rx_valid !== 1'b1 && ++n < 40);
        @(negedge sys_clk);
    endtask

    task automatic rst_chk;
        sys_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({digital_oe, bus_relay, online_led}, 8'h00);
        $display("reset test done");
    endtask

    task automatic set_row(input int i);
        local_health = OWN_H[i];
        stable_tb = OWN_S[i];
        peer_stat = '{online: 1'b0, stable_tb: PEER_S[i], nonce: 8'h33, health: PEER_H[i]};
        exch();
        exch();
    endtask

    initial begin
        jumper = 1'b1;
        clk_en = 1'b1;
        wdog = 1'b0;
        {shape_ok, level_ok, loop_ok, locked} = 4'hF;
        {stable_tb, mute, fail} = 3'h0;
        local_health = 8'h10;
        peer_stat = '0;
        num_errors = 0;
        samples_checked = 0;
        rst_chk();
        for (int i = 0; i < 5; i++) begin
            set_row(i);
            chk({digital_oe, bus_relay, online_led}, {5'h00, {3{EXP_ON[i]}}});
            chk(tx_status.health, OWN_H[i]);
            $display("row %0d done", i);
        end
        // Falling edges from the one after the taken status to the send pulse are a period less three.
        n = 0;
        do @(negedge sys_clk); while (tx_send !== 1'b1 && ++n < 40);
        chk(n[7:0], 8'(SEC - 3));
        set_row(0);
        wdog = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk({disable_out, digital_oe, fault_relay, fault_led}, 8'h09);
        exch();
        chk(digital_oe, 8'h00);
        wdog = 1'b0;
        exch();
        exch();
        chk({disable_out, digital_oe, fault_relay}, 8'h03);
        $display("watchdog test done");
        set_row(1);
        fail = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk(digital_oe, 8'h01);
        exch();
        chk(online_led, 8'h01);
        fail = 1'b0;
        exch();
        exch();
        jumper = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk({digital_oe, bus_relay, online_led}, 8'h06);
        jumper = 1'b1;
        $display("disable and jumper tests done");
        for (int i = 0; i < 4; i++) begin
            {shape_ok, level_ok, loop_ok} = BUS[i];
            repeat (4) @(negedge sys_clk);
            chk({bus_fault, fault_led, fault_report, fault_relay},
                (BUS[i] != 3'h7) ? 8'h0E : 8'h01);
        end
        locked = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(unlocked_relay, 8'h00);
        locked = 1'b1;
        repeat (4) @(negedge sys_clk);
        chk(unlocked_relay, 8'h01);
        $display("monitor test done");
        clk_en = 1'b0;
        jumper = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(digital_oe, 8'h00);
        jumper = 1'b1;
        clk_en = 1'b1;
        repeat (4) @(negedge sys_clk);
        $display("clock enable test done");
        mute = 1'b1;
        repeat (SEC * 4 + 6) @(negedge sys_clk);
        chk({peer_lost, digital_oe}, 8'h03);
        $display("peer loss test done");
        rst_chk();
        stop_test();
    end
endmodule

`default_nettype wire
